// ==== hw/htx_defs.svh ====
// constants for the frame transmitter: selects, patterns, counts, resets
`ifndef HTX_DEFS_SVH
`define HTX_DEFS_SVH
`define HTX_SEL_CONT 2'h2
`define HTX_SEL_TERM 2'h3
`define HTX_FLAG 16'h007E
`define HTX_ONES 16'hFFFF
`define HTX_CRC_INIT 16'hFFFF
`define HTX_CRC_POLY 16'h8408
`define HTX_BYTE_BITS 5'h08
`define HTX_FCS_BITS 5'h10
`define HTX_ABORT_BITS 5'h08
`define HTX_ABORT_EXT_BITS 5'h10
`define HTX_STUFF_RUN 3'h5
`define HTX_RST_RXRESET 1'b1
`define HTX_RST_TXRESET 1'b1
`define HTX_RST_FLAGIDLE 1'b0
`define HTX_RST_ONEBYTE 1'b1
`define HTX_RST_ABORTEXT 1'b0
`endif

// ==== hw/htx_pkg.sv ====
// shared types of the frame transmitter
package htx_pkg;
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } htx_word_s;
    typedef struct packed {
        logic rxReset;
        logic txReset;
        logic flagIdle;
        logic oneByte;
        logic abort;
        logic abortExt;
    } htx_ctrl_s;
    typedef enum logic [2:0] {
        S_MARK, S_FILL, S_OPEN, S_DATA, S_FCS, S_CLOSE, S_ABORT
    } htx_state_e;
endpackage

// ==== hw/htx_fifo.sv ====
// synchronous word fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module htx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH) + 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inWord,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outWord,
    output logic [CW-1:0] count
);
    localparam int AW = CW - 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0] wrPtr_q;
    logic [CW-1:0] rdPtr_q;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign count = wrPtr_q - rdPtr_q;
    assign inReady = (count != CW'(DEPTH)) && !flush;
    assign outValid = (count != '0) && !flush;
    assign outWord = mem[rdPtr_q[AW-1:0]];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // storage array, no reset needed on the data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inWord;
        end
    end

    // pointers; flush empties in one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

// ==== hw/htx_top.sv ====
// bit-oriented frame transmitter: reset latch, idle fill and frame start
`timescale 1ns/10ps
module htx_top
    import htx_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH) + 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ctrlWr,
    input wire htx_ctrl_s ctrlIn,
    input wire logic txWr,
    input wire logic [1:0] regSel,
    input wire logic [7:0] serial_out_line,
    input wire logic ctsPin,
    input wire logic txBitClk,
    output logic serialOut,
    output logic txRoom,
    output logic underrunFlag,
    output logic wrRefused,
    output logic rxInReset,
    output logic txInReset
);
`include "htx_defs.svh"
    // ---------------- host clock domain ----------------
    htx_ctrl_s ctrl_q;
    logic cts1_q, cts2_q;
    logic txRoom_q, underrun_q, wrRefused_q;
    logic abtTgl_q, reqTgl_q, pend_q;
    htx_word_s xferWord_q;
    logic ack1_q, ack2_q, ack3_q;
    logic un1_q, un2_q, un3_q;
    logic abortCmd, fifoFlush, selOk, inValid, inReady;
    logic outValid, outReady;
    htx_word_s inWord, outWord;
    logic [CW-1:0] fifoCnt;
    // ---------------- link clock domain ----------------
    htx_state_e state_q;
    logic [15:0] sh_q, crc_q, crcNext;
    logic [4:0] cnt_q;
    logic [2:0] ones_q;
    logic last_q, holdV_q, ackTgl_q, unTgl_q, serialOut_q;
    htx_word_s hold_q;
    logic lr1_q, linkRst;
    logic rq1_q, rq2_q, rq3_q, ab1_q, ab2_q, ab3_q;
    logic fi1_q, flagIdleS, ex1_q, abortExtS;
    logic reqEv, abortEv, stuffNow, endBit, wantByte, loadNow, take;

    // control bits; hard reset forces both sections into reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q.rxReset <= `HTX_RST_RXRESET;
            ctrl_q.txReset <= `HTX_RST_TXRESET;
            ctrl_q.flagIdle <= `HTX_RST_FLAGIDLE;
            ctrl_q.oneByte <= `HTX_RST_ONEBYTE;
            ctrl_q.abort <= 1'b0;
            ctrl_q.abortExt <= `HTX_RST_ABORTEXT;
        end else if (ctrlWr) begin
            // zero releases, one re-enters reset; async reset
            // wins while the pin is low
            ctrl_q <= ctrlIn;
            ctrl_q.abort <= 1'b0; // abort is a command, not stored
        end
    end

    assign abortCmd = ctrlWr && ctrlIn.abort && !ctrl_q.txReset;
    assign fifoFlush = ctrl_q.txReset || abortCmd;
    assign selOk = (regSel == `HTX_SEL_CONT) || (regSel == `HTX_SEL_TERM);
    assign inValid = txWr && selOk && !ctrl_q.txReset;
    assign inWord.data = serial_out_line;
    assign inWord.last = (regSel == `HTX_SEL_TERM);
    assign outReady = !pend_q;

    htx_fifo #(.WIDTH($bits(htx_word_s)), .DEPTH(DEPTH), .CW(CW)) u_fifo (
        .clk(ref_clk),
        .rstn(rstn),
        .flush(fifoFlush),
        .inValid(inValid),
        .inReady(inReady),
        .inWord(inWord),
        .outValid(outValid),
        .outReady(outReady),
        .outWord(outWord),
        .count(fifoCnt)
    );

    // clear-to-send pin synchroniser
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cts1_q <= 1'b1;
            cts2_q <= 1'b1;
        end else begin
            cts1_q <= ctsPin;
            cts2_q <= cts1_q;
        end
    end

    // room status; two-byte mode needs two free slots
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txRoom_q <= 1'b0;
        end else if (ctrl_q.txReset || cts2_q) begin
            txRoom_q <= 1'b0;
        end else if (ctrl_q.oneByte) begin
            txRoom_q <= fifoCnt <= CW'(DEPTH - 1);
        end else begin
            txRoom_q <= fifoCnt <= CW'(DEPTH - 2);
        end
    end

    // a write that the queue did not take is reported for one cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrRefused_q <= 1'b0;
        end else begin
            wrRefused_q <= txWr && !(inValid && inReady);
        end
    end

    // word handoff to the link: word held stable while request pends
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
            reqTgl_q <= 1'b0;
            xferWord_q <= '0;
        end else if (ctrl_q.txReset) begin
            pend_q <= 1'b0;
            reqTgl_q <= 1'b0;
        end else if (outValid && outReady) begin
            xferWord_q <= outWord;
            reqTgl_q <= !reqTgl_q;
            pend_q <= 1'b1;
        end else if (ack2_q ^ ack3_q) begin
            pend_q <= 1'b0;
        end
    end

    // abort command crosses as a toggle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            abtTgl_q <= 1'b0;
        end else if (abortCmd) begin
            abtTgl_q <= !abtTgl_q;
        end
    end

    // acknowledge and underrun toggles back from the link
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack1_q <= 1'b0;
            ack2_q <= 1'b0;
            ack3_q <= 1'b0;
            un1_q <= 1'b0;
            un2_q <= 1'b0;
            un3_q <= 1'b0;
        end else begin
            ack1_q <= ackTgl_q;
            ack2_q <= ack1_q;
            ack3_q <= ack2_q;
            un1_q <= unTgl_q;
            un2_q <= un1_q;
            un3_q <= un2_q;
        end
    end

    // sticky underrun; a new event beats the reset clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            underrun_q <= 1'b0;
        end else begin
            underrun_q <= (un2_q ^ un3_q) ||
                (underrun_q && !ctrl_q.txReset);
        end
    end

    assign txRoom = txRoom_q;
    assign underrunFlag = underrun_q;
    assign wrRefused = wrRefused_q;
    assign rxInReset = ctrl_q.rxReset;
    assign txInReset = ctrl_q.txReset;
    assign serialOut = serialOut_q;

    // level crossings into the link domain
    always_ff @(posedge txBitClk or negedge rstn) begin
        if (!rstn) begin
            lr1_q <= 1'b1;
            linkRst <= 1'b1;
            fi1_q <= 1'b0;
            flagIdleS <= 1'b0;
            ex1_q <= 1'b0;
            abortExtS <= 1'b0;
        end else begin
            lr1_q <= ctrl_q.txReset;
            linkRst <= lr1_q;
            fi1_q <= ctrl_q.flagIdle;
            flagIdleS <= fi1_q;
            ex1_q <= ctrl_q.abortExt;
            abortExtS <= ex1_q;
        end
    end

    // toggle synchronisers for request and abort
    always_ff @(posedge txBitClk or negedge rstn) begin
        if (!rstn) begin
            rq1_q <= 1'b0;
            rq2_q <= 1'b0;
            rq3_q <= 1'b0;
            ab1_q <= 1'b0;
            ab2_q <= 1'b0;
            ab3_q <= 1'b0;
        end else begin
            rq1_q <= reqTgl_q;
            rq2_q <= rq1_q;
            rq3_q <= rq2_q;
            ab1_q <= abtTgl_q;
            ab2_q <= ab1_q;
            ab3_q <= ab2_q;
        end
    end

    assign reqEv = rq2_q ^ rq3_q;
    assign abortEv = (ab2_q ^ ab3_q) && !linkRst;
    // stuffing also guards the first bit of the closing flag
    assign stuffNow = (ones_q == `HTX_STUFF_RUN) &&
        (state_q == S_DATA || state_q == S_FCS ||
        (state_q == S_CLOSE && cnt_q == `HTX_BYTE_BITS));
    assign endBit = (cnt_q == 5'h01) && !stuffNow;
    assign wantByte = endBit && (state_q == S_FILL ||
        state_q == S_OPEN || state_q == S_CLOSE ||
        (state_q == S_DATA && !last_q));
    assign loadNow = wantByte && holdV_q && !abortEv;
    assign take = holdV_q && (loadNow || abortEv);
    assign crcNext = {1'b0, crc_q[15:1]} ^
        ((crc_q[0] ^ sh_q[0]) ? `HTX_CRC_POLY : 16'h0000);

    // holding register at the link; consumed words are acknowledged
    always_ff @(posedge txBitClk or negedge rstn) begin
        if (!rstn) begin
            holdV_q <= 1'b0;
            hold_q <= '0;
            ackTgl_q <= 1'b0;
        end else if (linkRst) begin
            // toggles keep their level so reset makes no false event
            holdV_q <= 1'b0;
        end else if (abortEv) begin
            // abort drops the held word, also one landing this edge,
            // so a flushed byte cannot reopen a frame afterwards
            holdV_q <= 1'b0;
            if (holdV_q || reqEv) begin
                ackTgl_q <= !ackTgl_q;
            end
        end else if (reqEv) begin
            holdV_q <= 1'b1;
            hold_q <= xferWord_q;
        end else if (take) begin
            holdV_q <= 1'b0;
            ackTgl_q <= !ackTgl_q;
        end
    end

    // serialiser: idle, flags, stuffed data, check field, abort
    always_ff @(posedge txBitClk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_MARK;
            sh_q <= '0;
            cnt_q <= '0;
            ones_q <= '0;
            crc_q <= `HTX_CRC_INIT;
            last_q <= 1'b0;
            unTgl_q <= 1'b0;
            serialOut_q <= 1'b1;
        end else if (linkRst) begin
            // underrun toggle is left alone: clearing it would fake one
            state_q <= S_MARK;
            ones_q <= '0;
            serialOut_q <= 1'b1;
        end else if (abortEv) begin
            state_q <= S_ABORT;
            sh_q <= `HTX_ONES;
            cnt_q <= abortExtS ? `HTX_ABORT_EXT_BITS
                : `HTX_ABORT_BITS;
            serialOut_q <= 1'b1;
        end else if (stuffNow) begin
            serialOut_q <= 1'b0;
            ones_q <= '0;
        end else if (loadNow) begin
            // next byte follows with no gap, also after a shared flag
            serialOut_q <= sh_q[0];
            state_q <= S_DATA;
            sh_q <= {8'h00, hold_q.data};
            cnt_q <= `HTX_BYTE_BITS;
            last_q <= hold_q.last;
            if (state_q == S_DATA) begin
                crc_q <= crcNext;
                ones_q <= sh_q[0] ? ones_q + 3'h1 : 3'h0;
            end else begin
                crc_q <= `HTX_CRC_INIT;
                ones_q <= '0;
            end
        end else begin
            case (state_q)
                S_MARK: begin
                    serialOut_q <= 1'b1;
                    ones_q <= '0;
                    if (holdV_q) begin
                        state_q <= S_OPEN;
                        sh_q <= `HTX_FLAG;
                        cnt_q <= `HTX_BYTE_BITS;
                    end else if (flagIdleS) begin
                        state_q <= S_FILL;
                        sh_q <= `HTX_FLAG;
                        cnt_q <= `HTX_BYTE_BITS;
                    end
                end
                S_FILL, S_OPEN, S_CLOSE: begin
                    serialOut_q <= sh_q[0];
                    sh_q <= {1'b0, sh_q[15:1]};
                    cnt_q <= cnt_q - 5'h01;
                    ones_q <= '0;
                    if (endBit) begin
                        if (flagIdleS) begin
                            state_q <= S_FILL;
                            sh_q <= `HTX_FLAG;
                            cnt_q <= `HTX_BYTE_BITS;
                        end else begin
                            state_q <= S_MARK;
                        end
                    end
                end
                S_DATA, S_FCS: begin
                    serialOut_q <= sh_q[0];
                    sh_q <= {1'b0, sh_q[15:1]};
                    cnt_q <= cnt_q - 5'h01;
                    ones_q <= sh_q[0] ? ones_q + 3'h1 : 3'h0;
                    if (state_q == S_DATA) begin
                        crc_q <= crcNext;
                    end
                    if (endBit && state_q == S_DATA && last_q) begin
                        state_q <= S_FCS;
                        sh_q <= ~crcNext;
                        cnt_q <= `HTX_FCS_BITS;
                    end else if (endBit && state_q == S_DATA) begin
                        state_q <= S_ABORT;
                        sh_q <= `HTX_ONES;
                        cnt_q <= `HTX_ABORT_BITS;
                        unTgl_q <= !unTgl_q;
                    end else if (endBit) begin
                        state_q <= S_CLOSE;
                        sh_q <= `HTX_FLAG;
                        cnt_q <= `HTX_BYTE_BITS;
                    end
                end
                S_ABORT: begin
                    serialOut_q <= 1'b1;
                    ones_q <= '0;
                    cnt_q <= cnt_q - 5'h01;
                    if (endBit) begin
                        state_q <= S_MARK;
                    end
                end
                default: begin
                    state_q <= S_MARK;
                    serialOut_q <= 1'b1;
                end
            endcase
        end
    end

    // ---------------- checks ----------------
    sequence s_openFlag;
        state_q == S_OPEN ##1 !serialOut_q;
    endsequence
    property p_openFromMark;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_MARK && holdV_q && !abortEv |=> s_openFlag;
    endproperty
    a_openFromMark: assert property (p_openFromMark)
        else $error("no opening flag after byte in mark idle");
    property p_markOnes;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_MARK && !abortEv |=> serialOut_q;
    endproperty
    a_markOnes: assert property (p_markOnes)
        else $error("mark idle not at one level");
    property p_fillToData;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_FILL && endBit && holdV_q && !abortEv
        |=> state_q == S_DATA;
    endproperty
    a_fillToData: assert property (p_fillToData)
        else $error("fill flag not used as opening flag");
    property p_stuff;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_DATA && ones_q == 3'h5 && !abortEv
        |=> !serialOut_q && ones_q == 3'h0;
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("zero not inserted after five ones");
    property p_abortOnes;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        abortEv |=> serialOut_q [*8];
    endproperty
    a_abortOnes: assert property (p_abortOnes)
        else $error("abort shorter than eight ones");
    property p_underrun;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_DATA && endBit && !last_q && !holdV_q && !abortEv
        |=> state_q == S_ABORT && $changed(unTgl_q);
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun did not abort the frame");
    property p_terminate;
        @(posedge txBitClk) disable iff (!rstn || linkRst)
        state_q == S_DATA && endBit && last_q && !abortEv
        |=> state_q == S_FCS && cnt_q == 5'h10;
    endproperty
    a_terminate: assert property (p_terminate)
        else $error("last byte not followed by check field");
    property p_roomHeld;
        @(posedge ref_clk) disable iff (!rstn)
        ctrl_q.txReset || cts2_q |=> !txRoom_q;
    endproperty
    a_roomHeld: assert property (p_roomHeld)
        else $error("room status active in reset or clear-to-send");
    property p_noPreload;
        @(posedge ref_clk) disable iff (!rstn)
        txWr && ctrl_q.txReset |=> wrRefused_q && fifoCnt == '0;
    endproperty
    a_noPreload: assert property (p_noPreload)
        else $error("queue took data while in reset");
    property p_rstQuiet;
        @(posedge txBitClk) disable iff (!rstn)
        linkRst |=> serialOut_q && state_q == S_MARK;
    endproperty
    a_rstQuiet: assert property (p_rstQuiet)
        else $error("serial line moved during reset");
endmodule

// ==== sim/htx_remote_model.sv ====
// remote station: makes the bit clock and decodes the line
`timescale 1ns/10ps
module htx_remote_model (
    output logic txBitClk,
    input wire logic serialOut
);
    int ones = 0;
    int peak = 0;
    int zeros = 0;
    int flags = 0;
    int nBits = 0;
    logic inFrame = 1'h0;
    logic [7:0] hist = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] bytes[$];
    // modem clock runs free so that idle fill can advance
    initial begin
        txBitClk = 1'h0;
        #7;
        forever #16 txBitClk = ~txBitClk;
    end
    task automatic clr();
        peak = 0;
        zeros = 0;
        flags = 0;
        bytes.delete();
    endtask
    // bits arrive lsb first
    task automatic push(input logic b);
        sh = {b, sh[7:1]};
        nBits++;
        if (nBits == 8) begin
            bytes.push_back(sh);
            nBits = 0;
        end
    endtask
    // sample mid-bit, away from the launching edge
    always @(negedge txBitClk) begin
        hist = {serialOut, hist[7:1]};
        if (serialOut !== 1'h1) begin
            zeros++;
            if (hist === 8'h7E) begin
                flags++;
                inFrame = 1'h1;
                nBits = 0;
            end else if (inFrame && ones != 5) begin
                push(1'h0);
            end
            ones = 0;
        end else begin
            ones++;
            peak = (ones > peak) ? ones : peak;
            // seven ones end any frame: abort or idle
            if (ones > 6) begin
                inFrame = 1'h0;
            end else if (inFrame) begin
                push(1'h1);
            end
        end
    end
endmodule

// ==== sim/htx_top_tb.sv ====
// self-checking bench for the frame transmitter
`timescale 1ns/10ps
module htx_top_tb;
    import htx_pkg::*;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic ctrlWr = 1'h0;
    htx_ctrl_s ctrlIn = '0;
    logic txWr = 1'h0;
    logic [1:0] regSel = 2'h0;
    logic [7:0] serial_out_line = 8'h00;
    logic ctsPin = 1'h0;
    logic txBitClk, serialOut, txRoom, underrunFlag;
    logic wrRefused, rxInReset, txInReset;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 ref_clk = ~ref_clk;
    htx_top dut (.ref_clk(ref_clk), .rstn(rstn), .ctrlWr(ctrlWr),
        .ctrlIn(ctrlIn), .txWr(txWr), .regSel(regSel),
        .serial_out_line(serial_out_line), .ctsPin(ctsPin), .txBitClk(txBitClk),
        .serialOut(serialOut), .txRoom(txRoom),
        .underrunFlag(underrunFlag), .wrRefused(wrRefused),
        .rxInReset(rxInReset), .txInReset(txInReset));
    htx_remote_model far (.txBitClk(txBitClk), .serialOut(serialOut));
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'h1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // bits rx tx flagIdle oneByte abort abortExt, msb first
    task automatic ctl(input logic [5:0] v);
        @(posedge ref_clk);
        ctrlWr <= 1'h1;
        ctrlIn <= v;
        @(posedge ref_clk);
        ctrlWr <= 1'h0;
        #1;
    endtask
    // strobe low one cycle between writes, never reasserted same step
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge ref_clk);
        txWr <= 1'h1;
        regSel <= s;
        serial_out_line <= d;
        @(posedge ref_clk);
        txWr <= 1'h0;
        #1;
    endtask
    task automatic t_reset();
        cw(5);
        ctl(6'h04);
        cw(12);
        @(posedge ref_clk);
        rstn <= 1'h1;
        cw(3);
        chk(txInReset === 1'h1 && rxInReset === 1'h1, "not latched");
        chk(txRoom === 1'h0 && serialOut === 1'h1, "not quiet");
        wr(2'h2, 8'h55);
        chk(wrRefused === 1'h1, "write taken in reset");
    endtask
    task automatic t_release();
        ctl(6'h04);
        cw(2);
        chk(txInReset === 1'h0 && rxInReset === 1'h0, "no release");
        @(posedge ref_clk);
        ctsPin <= 1'h1;
        cw(6);
        chk(txRoom === 1'h0, "room with cts high");
        @(posedge ref_clk);
        ctsPin <= 1'h0;
        cw(6);
        chk(txRoom === 1'h1, "no room");
        far.clr();
        cw(40);
        chk(far.zeros == 0, "mark idle broken");
    endtask
    task automatic t_badsel();
        for (int s = 0; s < 2; s++) begin
            wr(2'(s), 8'h11);
            chk(wrRefused === 1'h1, "bad select taken");
        end
    endtask
    task automatic t_frame(input logic fi);
        int i;
        ctl({2'h0, fi, 3'h4});
        cw(80);
        far.clr();
        wr(2'h2, 8'hFF);
        chk(wrRefused === 1'h0, "address refused");
        wr(2'h3, 8'h3C);
        for (i = 0; i < 70 && far.flags == 0; i++) @(posedge ref_clk);
        chk(far.flags > 0, "no opening flag");
        for (i = 0; i < 600 && far.bytes.size() < 4; i++) @(posedge ref_clk);
        cw(40);
        chk(far.bytes.size() == 4 && far.flags > 1, "bad close");
        chk(far.bytes[0] === 8'hFF && far.bytes[1] === 8'h3C, "data");
        if (fi) chk(far.peak <= 6, "six ones exceeded");
    endtask
    task automatic t_abort(input logic ae);
        ctl({5'h06, ae});
        cw(80);
        wr(2'h2, 8'hA5);
        wr(2'h2, 8'h5A);
        wr(2'h2, 8'h0F);
        cw(30);
        far.clr();
        ctl({5'h07, ae});
        cw(300);
        chk(far.peak >= (ae ? 16 : 8), "abort too short");
        far.clr();
        cw(200);
        chk(far.bytes.size() == 0 && far.flags > 0, "not flushed");
    endtask
    task automatic t_fill();
        int i;
        int nRef;
        int nLow;
        nRef = 0;
        nLow = 0;
        ctl(6'h0C);
        cw(80);
        far.clr();
        for (i = 0; i < 24; i++) begin
            wr(2'h2, 8'(i));
            nRef += (wrRefused === 1'h1);
            nLow += (txRoom === 1'h0);
        end
        chk(nRef > 0 && nLow > 0, "queue never full");
        // two-byte mode on a full queue: room must mean two writes fit
        ctl(6'h08);
        cw(2);
        for (i = 0; i < 200 && txRoom !== 1'h1; i++) @(posedge ref_clk);
        chk(txRoom === 1'h1, "no room in two-byte mode");
        wr(2'h2, 8'h40);
        chk(wrRefused === 1'h0, "first of two refused");
        wr(2'h2, 8'h41);
        chk(wrRefused === 1'h0, "second of two refused");
        for (i = 0; i < 2000 && underrunFlag !== 1'h1; i++) @(posedge ref_clk);
        cw(60);
        chk(underrunFlag === 1'h1 && far.peak >= 8, "no underrun");
        chk(far.bytes.size() >= 23 - nRef, "bytes lost");
        chk(far.bytes[0] === 8'h00, "first byte");
        ctl(6'h3C);
        cw(8);
        chk(txInReset === 1'h1 && rxInReset === 1'h1, "no reset");
        chk(txRoom === 1'h0 && underrunFlag === 1'h0, "kept");
    endtask
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // the full run needs about 2700 cycles; cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("CHECK FAILED %0t timeout", $time);
            print_verdict();
        end
    end
    initial begin
        t_reset();
        t_release();
        t_badsel();
        t_frame(1'h0);
        t_frame(1'h1);
        t_abort(1'h0);
        t_abort(1'h1);
        t_fill();
        print_verdict();
    end
endmodule
